// *** common/tcc_pkg.sv ***
// Shared constants and types of the two-channel conversion controller
package tcc_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_HZ    = 32'h0773_5940;           // 125 MHz
  localparam int MS_CYCLES = CLK_HZ / 32'h0000_03e8;  // Cycles per ms
  localparam int SENSE_MS  = 32'h0000_003c;           // 60 ms sensing
  localparam int AVG_N     = 32'h0000_000a;           // 10 per channel
  localparam int SLOT_MS   = SENSE_MS / (2 * AVG_N);  // One sample slot

  // Interval in ms at rate code zero, halved per code step
  localparam logic [13:0] BASE_IVL_MS = 14'h3e80;
  localparam logic [7:0]  RATE_MAX    = 8'h07;

  // ****************
  // Register map (byte offsets)
  // ****************
  localparam logic [7:0] OFF_LTEMP   = 8'h00;
  localparam logic [7:0] OFF_RTEMP   = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_CONFIG  = 8'h0c;
  localparam logic [7:0] OFF_RATE    = 8'h10;
  localparam logic [7:0] OFF_LHIGH   = 8'h14;
  localparam logic [7:0] OFF_LLOW    = 8'h18;
  localparam logic [7:0] OFF_RHIGH   = 8'h1c;
  localparam logic [7:0] OFF_RLOW    = 8'h20;
  localparam logic [7:0] OFF_ONESHOT = 8'h24;
  localparam logic [7:0] OFF_SLVADDR = 8'h28;

  // Reset values
  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [7:0] RST_CFG  = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_HIGH = 8'h7f;
  localparam logic [7:0] RST_LOW  = 8'hc9;

  // Field positions
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_HALT_BIT = 6;
  localparam int ST_BUSY      = 7;
  localparam int ST_LHI       = 6;
  localparam int ST_LLO       = 5;
  localparam int ST_RHI       = 4;
  localparam int ST_RLO       = 3;

  // ****************
  // Address select levels and slave addresses
  // ****************
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_NC   = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  localparam logic [6:0] SADDR_LL = 7'h18;
  localparam logic [6:0] SADDR_LN = 7'h19;
  localparam logic [6:0] SADDR_LH = 7'h1a;
  localparam logic [6:0] SADDR_NL = 7'h29;
  localparam logic [6:0] SADDR_NN = 7'h2a;
  localparam logic [6:0] SADDR_NH = 7'h2b;
  localparam logic [6:0] SADDR_HL = 7'h4c;
  localparam logic [6:0] SADDR_HN = 7'h4d;
  localparam logic [6:0] SADDR_HH = 7'h4e;

  // Conversion states, Gray along idle, sense, store
  typedef enum logic [1:0] {
    TCC_IDLE  = 2'h0,
    TCC_SENSE = 2'h1,
    TCC_STORE = 2'h3
  } tcc_state_e;

endpackage : tcc_pkg

// *** verilog/tcc_tick.sv ***
// Millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module tcc_tick #(
  parameter int DIV = 125000
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output var  logic tick_o
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // Free-running count, one pulse per wrap
  always_comb
  begin
    next_tick = (cnt == LAST);
    next_cnt  = next_tick ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule : tcc_tick
`default_nettype wire

// *** verilog/tcc_avg.sv ***
// Accumulate N signed samples and give their mean
`timescale 1ns/1ps
`default_nettype none
module tcc_avg #(
  parameter int N = 10
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       clr_i,
  input  wire logic       smp_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] avg_o
);
  logic signed [11:0] acc;
  logic signed [11:0] next_acc;
  logic signed [11:0] quo;

  // Clear starts a fresh sum; a sample in the same cycle is kept
  always_comb
  begin
    next_acc = clr_i ? 12'sh000 : acc;
    if (smp_i)
    begin
      next_acc = next_acc + 12'($signed(data_i));
    end
    quo   = acc / $signed(12'(N));  // Truncates toward zero
    avg_o = quo[7:0];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc <= 12'sh000;
    end
    else
    begin
      acc <= next_acc;
    end
  end
endmodule : tcc_avg
`default_nettype wire

// *** verilog/tcc_ctrl.sv ***
// Two-channel temperature conversion controller with AHB-Lite registers
//
// Behaviour
// - No clock-low timeout on the serial link
// - Auto conversions only when standby high, halt low
// - One-shot command starts a conversion
// - Interval follows conversion rate register, rewritable
// - Sense remote then local, about 60 ms
// - Results stored as 8-bit two's complement
// - Compare results against per-channel high/low limits
// - Comparison outcomes shown as status flags
// - Out-of-limit result pulls alert low
// - Both temperatures update together on success
// - Each result averages ten measurements
// - Address pins decode to low, high, open
// - Latch address pins at each conversion start
// - Soft halt stops periodic; one-shot still converts
// - Mask bit set suppresses alert
// - Hardware standby blocks, aborts conversions, drops one-shot
// - Nine pin combinations map to fixed addresses
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl #(
  parameter int MS_CYCLES = tcc_pkg::MS_CYCLES,
  parameter int AVG_N     = tcc_pkg::AVG_N,
  parameter int SLOT_MS   = tcc_pkg::SLOT_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  // Pins and converter
  input  wire logic        hw_standby_n_i,
  input  wire logic [1:0]  addr_sel_a_i,
  input  wire logic [1:0]  addr_sel_b_i,
  input  wire logic [7:0]  meas_data_i,
  output var  logic        meas_active_o,
  output var  logic        meas_chan_o,
  output var  logic        alert_o,
  output var  logic        alert_oe_o,
  output var  logic [6:0]  slave_addr_o
);

  // ****************
  // Functions
  // ****************

  // Three-level pin pair to slave address; an illegal code reads open
  function automatic logic [6:0] tcc_saddr(input logic [1:0] a,
                                           input logic [1:0] b);
    logic [1:0] la;
    logic [1:0] lb;
    logic [6:0] r;
    la = (a == 2'h3) ? tcc_pkg::LVL_NC : a;
    lb = (b == 2'h3) ? tcc_pkg::LVL_NC : b;
    unique case ({la, lb})
      {tcc_pkg::LVL_LOW,  tcc_pkg::LVL_LOW}:  r = tcc_pkg::SADDR_LL;
      {tcc_pkg::LVL_LOW,  tcc_pkg::LVL_NC}:   r = tcc_pkg::SADDR_LN;
      {tcc_pkg::LVL_LOW,  tcc_pkg::LVL_HIGH}: r = tcc_pkg::SADDR_LH;
      {tcc_pkg::LVL_NC,   tcc_pkg::LVL_LOW}:  r = tcc_pkg::SADDR_NL;
      {tcc_pkg::LVL_NC,   tcc_pkg::LVL_NC}:   r = tcc_pkg::SADDR_NN;
      {tcc_pkg::LVL_NC,   tcc_pkg::LVL_HIGH}: r = tcc_pkg::SADDR_NH;
      {tcc_pkg::LVL_HIGH, tcc_pkg::LVL_LOW}:  r = tcc_pkg::SADDR_HL;
      {tcc_pkg::LVL_HIGH, tcc_pkg::LVL_NC}:   r = tcc_pkg::SADDR_HN;
      default:                                r = tcc_pkg::SADDR_HH;
    endcase
    return r;
  endfunction : tcc_saddr

  // Rate code to interval in ms; codes above the top clamp to it
  function automatic logic [13:0] tcc_ivl(input logic [7:0] rate);
    logic [2:0] sh;
    sh = (rate > tcc_pkg::RATE_MAX) ? tcc_pkg::RATE_MAX[2:0] : rate[2:0];
    return tcc_pkg::BASE_IVL_MS >> sh;
  endfunction : tcc_ivl

  // Signed limit comparison
  function automatic logic tcc_gt(input logic [7:0] x,
                                  input logic [7:0] y);
    return $signed(x) > $signed(y);
  endfunction : tcc_gt

  // ****************
  // Input synchronisers
  // ****************
  logic [1:0] hw_standby_n_ff;
  logic [3:0] asel_ff1;
  logic [3:0] asel_ff2;
  logic [7:0] meas_ff1;
  logic [7:0] meas_ff2;
  logic       hw_standby_n_n;

  // Pins are asynchronous; converter word is quasi-static per slot
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hw_standby_n_ff  <= 2'h0;
      asel_ff1 <= 4'h0;
      asel_ff2 <= 4'h0;
      meas_ff1 <= 8'h00;
      meas_ff2 <= 8'h00;
    end
    else
    begin
      hw_standby_n_ff  <= {hw_standby_n_ff[0], hw_standby_n_i};
      asel_ff1 <= {addr_sel_a_i, addr_sel_b_i};
      asel_ff2 <= asel_ff1;
      meas_ff1 <= meas_data_i;
      meas_ff2 <= meas_ff1;
    end
  end
  assign hw_standby_n_n = hw_standby_n_ff[1];

  // ****************
  // Millisecond enable and averagers
  // ****************
  logic       tick;
  logic       avg_clr;
  logic       smp_r;
  logic       smp_l;
  logic [7:0] avg_r;
  logic [7:0] avg_l;

  tcc_tick #(.DIV(MS_CYCLES)) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_o (tick)
  );

  tcc_avg #(.N(AVG_N)) u_avg_remote (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .clr_i  (avg_clr),
    .smp_i  (smp_r),
    .data_i (meas_ff2),
    .avg_o  (avg_r)
  );

  tcc_avg #(.N(AVG_N)) u_avg_local (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .clr_i  (avg_clr),
    .smp_i  (smp_l),
    .data_i (meas_ff2),
    .avg_o  (avg_l)
  );

  // ****************
  // AHB-Lite slave
  // ****************
  logic        a_valid;
  logic        a_write;
  logic [7:0]  a_off;
  logic        next_a_valid;
  logic        next_a_write;
  logic [7:0]  next_a_off;
  logic [31:0] next_rdata;
  logic        take;
  logic        wr;

  // Register state
  logic [7:0]  ltemp;
  logic [7:0]  rtemp;
  logic [7:0]  cfg;
  logic [7:0]  rate;
  logic [7:0]  lhigh;
  logic [7:0]  llow;
  logic [7:0]  rhigh;
  logic [7:0]  rlow;
  logic [3:0]  flags;
  tcc_pkg::tcc_state_e state;

  // Zero wait states; no stall, no timeout, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign take        = hsel_i & htrans_i[1] & hready_i;
  assign wr          = a_valid & a_write;

  // Read data is fetched at the address phase so it stands in the data phase
  always_comb
  begin
    next_a_valid = take;
    next_a_write = hwrite_i;
    next_a_off   = haddr_i[7:0];
    next_rdata   = 32'h0000_0000;
    if (take && !hwrite_i)
    begin
      unique case (haddr_i[7:0])
        tcc_pkg::OFF_LTEMP:   next_rdata[7:0] = ltemp;
        tcc_pkg::OFF_RTEMP:   next_rdata[7:0] = rtemp;
        tcc_pkg::OFF_STATUS:  next_rdata[7:0] = {state != tcc_pkg::TCC_IDLE, flags,
                                                 3'h0};
        tcc_pkg::OFF_CONFIG:  next_rdata[7:0] = cfg;
        tcc_pkg::OFF_RATE:    next_rdata[7:0] = rate;
        tcc_pkg::OFF_LHIGH:   next_rdata[7:0] = lhigh;
        tcc_pkg::OFF_LLOW:    next_rdata[7:0] = llow;
        tcc_pkg::OFF_RHIGH:   next_rdata[7:0] = rhigh;
        tcc_pkg::OFF_RLOW:    next_rdata[7:0] = rlow;
        tcc_pkg::OFF_SLVADDR: next_rdata[6:0] = slave_addr_o;
        default:              next_rdata      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      a_valid  <= 1'b0;
      a_write  <= 1'b0;
      a_off    <= 8'h00;
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      a_valid  <= next_a_valid;
      a_write  <= next_a_write;
      a_off    <= next_a_off;
      hrdata_o <= next_rdata;
    end
  end

  // ****************
  // Software registers
  // ****************
  logic [7:0] next_cfg;
  logic [7:0] next_rate;
  logic [7:0] next_lhigh;
  logic [7:0] next_llow;
  logic [7:0] next_rhigh;
  logic [7:0] next_rlow;
  logic       rate_wr;
  logic       osht_wr;

  // Only the two used config bits hold state
  always_comb
  begin
    next_cfg   = cfg;
    next_rate  = rate;
    next_lhigh = lhigh;
    next_llow  = llow;
    next_rhigh = rhigh;
    next_rlow  = rlow;
    rate_wr    = wr && (a_off == tcc_pkg::OFF_RATE);
    osht_wr    = wr && (a_off == tcc_pkg::OFF_ONESHOT);
    if (wr)
    begin
      unique case (a_off)
        tcc_pkg::OFF_CONFIG:
        begin
          next_cfg[tcc_pkg::CFG_MASK_BIT] = hwdata_i[tcc_pkg::CFG_MASK_BIT];
          next_cfg[tcc_pkg::CFG_HALT_BIT] = hwdata_i[tcc_pkg::CFG_HALT_BIT];
        end
        tcc_pkg::OFF_RATE:  next_rate  = hwdata_i[7:0];
        tcc_pkg::OFF_LHIGH: next_lhigh = hwdata_i[7:0];
        tcc_pkg::OFF_LLOW:  next_llow  = hwdata_i[7:0];
        tcc_pkg::OFF_RHIGH: next_rhigh = hwdata_i[7:0];
        tcc_pkg::OFF_RLOW:  next_rlow  = hwdata_i[7:0];
        default:            next_cfg   = cfg;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg   <= tcc_pkg::RST_CFG;
      rate  <= tcc_pkg::RST_RATE;
      lhigh <= tcc_pkg::RST_HIGH;
      llow  <= tcc_pkg::RST_LOW;
      rhigh <= tcc_pkg::RST_HIGH;
      rlow  <= tcc_pkg::RST_LOW;
    end
    else
    begin
      cfg   <= next_cfg;
      rate  <= next_rate;
      lhigh <= next_lhigh;
      llow  <= next_llow;
      rhigh <= next_rhigh;
      rlow  <= next_rlow;
    end
  end

  // ****************
  // Conversion scheduler and sequencer
  // ****************
  logic        soft_halt_bit;
  logic        free_run;
  logic        osht_pend;
  logic [13:0] ivl;
  logic [3:0]  slot;
  logic [4:0]  idx;
  logic        start;
  logic        slot_end;
  tcc_pkg::tcc_state_e next_state;
  logic        next_osht_pend;
  logic [13:0] next_ivl;
  logic [3:0]  next_slot;
  logic [4:0]  next_idx;
  logic [7:0]  next_ltemp;
  logic [7:0]  next_rtemp;
  logic [3:0]  next_flags;
  logic [6:0]  next_saddr;
  logic        next_alert;

  assign soft_halt_bit = cfg[tcc_pkg::CFG_HALT_BIT];
  assign free_run      = hw_standby_n_n & ~soft_halt_bit;

  always_comb
  begin
    start = (state == tcc_pkg::TCC_IDLE) && hw_standby_n_n
            && (osht_pend || (free_run && ivl == 14'h0000));
    slot_end = tick && (slot == 4'(SLOT_MS - 1));
    // A command during a conversion waits; set beats consumption
    next_osht_pend = (osht_pend && !start) || osht_wr;
    if (!hw_standby_n_n)
    begin
      next_osht_pend = 1'b0;
    end
    // Rewriting the rate restarts the interval at the new value
    next_ivl = ivl;
    if (rate_wr)
    begin
      next_ivl = tcc_ivl(hwdata_i[7:0]);
    end
    else if (start)
    begin
      next_ivl = tcc_ivl(rate);
    end
    else if (tick && ivl != 14'h0000)
    begin
      next_ivl = ivl - 14'h0001;
    end
    next_state = state;
    next_slot  = slot;
    next_idx   = idx;
    next_ltemp = ltemp;
    next_rtemp = rtemp;
    next_flags = flags;
    next_saddr = slave_addr_o;
    avg_clr    = start;
    smp_r      = 1'b0;
    smp_l      = 1'b0;
    unique case (state)
      tcc_pkg::TCC_IDLE:
      begin
        if (start)
        begin
          next_state = tcc_pkg::TCC_SENSE;
          next_slot  = 4'h0;
          next_idx   = 5'h00;
          // Pins are expected static, so a fresh sample is harmless
          next_saddr = tcc_saddr(asel_ff2[3:2], asel_ff2[1:0]);
        end
      end
      tcc_pkg::TCC_SENSE:
      begin
        if (!hw_standby_n_n)
        begin
          next_state = tcc_pkg::TCC_IDLE;
        end
        else if (tick)
        begin
          next_slot = slot_end ? 4'h0 : slot + 4'h1;
          if (slot_end)
          begin
            // Remote samples first, then local
            smp_r    = (idx < 5'(AVG_N));
            smp_l    = !smp_r;
            next_idx = idx + 5'h01;
            if (idx == 5'(2 * AVG_N - 1))
            begin
              next_state = tcc_pkg::TCC_STORE;
            end
          end
        end
      end
      tcc_pkg::TCC_STORE:
      begin
        // Both results and all four flags change in one cycle
        next_ltemp = avg_l;
        next_rtemp = avg_r;
        next_flags = {tcc_gt(avg_l, lhigh), tcc_gt(llow, avg_l),
                      tcc_gt(avg_r, rhigh), tcc_gt(rlow, avg_r)};
        next_state = tcc_pkg::TCC_IDLE;
      end
      default:
      begin
        next_state = tcc_pkg::TCC_IDLE;
      end
    endcase
    // Open-drain alert pulls low on any flag unless masked
    next_alert = (|next_flags) && !cfg[tcc_pkg::CFG_MASK_BIT];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state        <= tcc_pkg::TCC_IDLE;
      osht_pend    <= 1'b0;
      ivl          <= 14'h0000;
      slot         <= 4'h0;
      idx          <= 5'h00;
      ltemp        <= tcc_pkg::RST_TEMP;
      rtemp        <= tcc_pkg::RST_TEMP;
      flags        <= 4'h0;
      slave_addr_o <= tcc_pkg::SADDR_LL;
      alert_oe_o   <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      osht_pend    <= next_osht_pend;
      ivl          <= next_ivl;
      slot         <= next_slot;
      idx          <= next_idx;
      ltemp        <= next_ltemp;
      rtemp        <= next_rtemp;
      flags        <= next_flags;
      slave_addr_o <= next_saddr;
      alert_oe_o   <= next_alert;
    end
  end

  // ****************
  // Converter steering and alert pin
  // ****************

  // Channel select: 1 remote, 0 local
  assign meas_active_o = (state == tcc_pkg::TCC_SENSE);
  assign meas_chan_o   = (state == tcc_pkg::TCC_SENSE) && (idx < 5'(AVG_N));
  assign alert_o       = 1'b0;                              // Drives low only

endmodule : tcc_ctrl
`default_nettype wire

// *** tb/tcc_conv_model.sv ***
// Behavioural model of the converter feeding samples to the controller
`timescale 1ns/1ps
`default_nettype none
module tcc_conv_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       active_i,
  input  wire logic       chan_i,
  input  wire logic [7:0] remote_i,
  input  wire logic [7:0] local_i,
  output var  logic [7:0] data_o
);
  // ****************
  // Sample output
  // ****************
  // Idle shows the remote reading, so a short first slot still samples it
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      data_o <= 8'h00;
    else if (!active_i || chan_i)
      data_o <= remote_i;
    else
      data_o <= local_i;
endmodule : tcc_conv_model
`default_nettype wire

// *** tb/tcc_ctrl_sva.sv ***
// Port checker of the conversion controller
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl_sva #(
  parameter int MS_CYCLES = 20,
  parameter int AVG_N     = 10,
  parameter int SLOT_MS   = 3
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hw_standby_n_i,
  input wire logic        meas_active_o,
  input wire logic        meas_chan_o,
  input wire logic        alert_oe_o,
  input wire logic [6:0]  slave_addr_o
);
  // ****************
  // Helpers
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  localparam int HALF = AVG_N * SLOT_MS * MS_CYCLES;
  localparam int SLOT = SLOT_MS * MS_CYCLES;
  logic cfg_wr;
  int   act_cnt;
  int   next_act_cnt;
  // Config write taken on the bus; it may move the alert through the mask
  assign cfg_wr = hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h0c;
  // Length of the running sense phase; the first slot may be short
  always_comb next_act_cnt = meas_active_o ? act_cnt + 1 : 0;
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      act_cnt <= 0;
    else
      act_cnt <= next_act_cnt;
  sequence s_start;
    $rose(meas_active_o);
  endsequence
  sequence s_end;
    $fell(meas_active_o);
  endsequence
  // ****************
  // Properties
  // ****************
  property p_remote_first; s_start |-> meas_chan_o; endproperty
  a_remote_first: assert property (p_remote_first) else $error("run opened on local");
  property p_chan_rise; $rose(meas_chan_o) |-> $rose(meas_active_o); endproperty
  a_chan_rise: assert property (p_chan_rise) else $error("remote reopened mid-run");
  property p_half; $fell(meas_chan_o) && meas_active_o |-> act_cnt inside {[HALF-SLOT:HALF+4]};
  endproperty
  a_half: assert property (p_half) else $error("remote half has wrong length");
  property p_conv_len; s_end ##0 hw_standby_n_i |-> act_cnt inside {[2*HALF-SLOT:2*HALF+4]};
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("sense phase has wrong length");
  property p_gap; s_end |=> !meas_active_o; endproperty
  a_gap: assert property (p_gap) else $error("runs overlap");
  property p_standby; !hw_standby_n_i [*5] |-> !meas_active_o; endproperty
  a_standby: assert property (p_standby) else $error("sensing in hw standby");
  property p_addr; $changed(slave_addr_o) |-> $rose(meas_active_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved outside a start");
  property p_alert;
    $changed(alert_oe_o) |-> $past(meas_active_o, 2) || $past(meas_active_o, 3)
      || $past(cfg_wr, 2) || $past(cfg_wr, 3) || $past(cfg_wr, 4);
  endproperty
  a_alert: assert property (p_alert) else $error("alert moved without cause");
endmodule : tcc_ctrl_sva
bind tcc_ctrl tcc_ctrl_sva #(.MS_CYCLES(MS_CYCLES), .AVG_N(AVG_N), .SLOT_MS(SLOT_MS)) u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hw_standby_n_i(hw_standby_n_i), .meas_active_o(meas_active_o),
  .meas_chan_o(meas_chan_o), .alert_oe_o(alert_oe_o), .slave_addr_o(slave_addr_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the conversion controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************
  // Signals and instances
  // ****************
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hw_standby_n_n = 1'b1;
  logic [1:0]  sel_a = 2'h0;
  logic [1:0]  sel_b = 2'h0;
  logic [7:0]  rem_v = 8'hfb;
  logic [7:0]  loc_v = 8'h32;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         act;
  wire         chan;
  wire         alert;
  wire         alert_oe;
  wire  [6:0]  saddr;
  wire  [7:0]  mdata;
  int          err_count = 0;
  int          checks_done = 0;
  always #4 clk_i = ~clk_i;
  tcc_ctrl #(.MS_CYCLES(20), .AVG_N(10), .SLOT_MS(3)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .hw_standby_n_i(hw_standby_n_n),
    .addr_sel_a_i(sel_a), .addr_sel_b_i(sel_b), .meas_data_i(mdata), .meas_active_o(act),
    .meas_chan_o(chan), .alert_o(alert), .alert_oe_o(alert_oe), .slave_addr_o(saddr));
  tcc_conv_model u_conv (
    .clk_i(clk_i), .rstn_i(rstn_i), .active_i(act), .chan_i(chan),
    .remote_i(rem_v), .local_i(loc_v), .data_o(mdata));
  // ****************
  // Shared tasks
  // ****************
  task final_report;
    $display("mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task fail_to(input string nm);
    $display("CHECK FAILED %s expected event seen timeout", nm);
    err_count++;
    final_report();
  endtask : fail_to
  task step(inout int n);
    @(posedge clk_i);
    n++;
  endtask : step
  task wait_rdy;
    int n;
    n = 0;
    do step(n); while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) fail_to("hready");
  endtask : wait_rdy
  // One single word transfer; read data is taken at the data phase edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task wait_act(input logic v, input int lim);
    int n;
    n = 0;
    while (act !== v && n < lim) step(n);
    if (act !== v) fail_to("conversion activity");
  endtask : wait_act
  task no_start(input int lim);
    int n;
    n = 0;
    while (act !== 1'b1 && n < lim) step(n);
    chk("idle cycles", lim, n);
  endtask : no_start
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rd_chk
  // ****************
  // Scenarios
  // ****************
  task t_regs;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[7]});
    rd_chk("config", 8'h0c, 32'h0);
    rd_chk("rate", 8'h10, 32'h02);
    for (int i = 0; i < 4; i++) rd_chk("limit", 8'(8'h14 + 4 * i), i[0] ? 32'hc9 : 32'h7f);
    rd_chk("unmapped", 8'h3c, 32'h0);
    chk("slave address", 32'h18, {25'h0, saddr});
    bus(1'b1, 8'h10, 32'h07);
  endtask : t_regs
  task t_conv;
    wait_act(1'b0, 1500);
    repeat (4) @(posedge clk_i);
    rd_chk("local temp", 8'h00, 32'h32);
    rd_chk("remote temp", 8'h04, 32'hfb);
    rd_chk("status", 8'h08, 32'h0);
    chk("alert", 32'h0, {31'h0, alert_oe});
    chk("pin and response", 32'h0, {30'h0, alert, hresp});
  endtask : t_conv
  // Start to start spacing after a rate rewrite
  task t_gap(input logic [7:0] r, input int exp);
    int n;
    bus(1'b1, 8'h10, {24'h0, r});
    wait_act(1'b0, 1300);
    wait_act(1'b1, 6000);
    n = 0;
    while (act === 1'b1 && n < 9000) step(n);
    while (act !== 1'b1 && n < 9000) step(n);
    chk("interval in range", 32'h1, {31'h0, n > exp - 40 && n < exp + 40});
  endtask : t_gap
  task t_limits;
    bus(1'b1, 8'h14, 32'h28);
    bus(1'b1, 8'h20, 32'h00);
    wait_act(1'b0, 1300);
    repeat (4) @(posedge clk_i);
    rd_chk("status", 8'h08, 32'h48);
    chk("alert", 32'h1, {31'h0, alert_oe});
    bus(1'b1, 8'h0c, 32'h80);
    repeat (4) @(posedge clk_i);
    chk("masked alert", 32'h0, {31'h0, alert_oe});
    rd_chk("config", 8'h0c, 32'h80);
  endtask : t_limits
  task t_halt;
    bus(1'b1, 8'h0c, 32'hc0);
    wait_act(1'b0, 6000);
    no_start(6000);
    bus(1'b1, 8'h24, 32'h0);
    wait_act(1'b1, 10);
    bus(1'b1, 8'h24, 32'h0);
    wait_act(1'b0, 1300);
    wait_act(1'b1, 10);
    wait_act(1'b0, 1300);
  endtask : t_halt
  task t_addr;
    logic [6:0] tbl [9];
    tbl = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e};
    for (int i = 0; i < 9; i++)
    begin
      sel_a <= 2'(i / 3);
      sel_b <= 2'(i % 3);
      repeat (4) @(posedge clk_i);
      bus(1'b1, 8'h24, 32'h0);
      wait_act(1'b1, 10);
      chk("slave address", {25'h0, tbl[i]}, {25'h0, saddr});
      wait_act(1'b0, 1300);
    end
  endtask : t_addr
  // Pins move and standby drops in mid-run; nothing may be stored
  task t_standby;
    rem_v <= 8'h10;
    bus(1'b1, 8'h24, 32'h0);
    wait_act(1'b1, 10);
    sel_a <= 2'h0;
    sel_b <= 2'h3;
    repeat (100) @(posedge clk_i);
    chk("held address", 32'h4e, {25'h0, saddr});
    hw_standby_n_n <= 1'b0;
    wait_act(1'b0, 8);
    bus(1'b1, 8'h24, 32'h0);
    no_start(1500);
    hw_standby_n_n <= 1'b1;
    no_start(1500);
    rd_chk("remote kept", 8'h04, 32'hfb);
    bus(1'b1, 8'h24, 32'h0);
    wait_act(1'b1, 10);
    chk("open code address", 32'h19, {25'h0, saddr});
    wait_act(1'b0, 1300);
    repeat (4) @(posedge clk_i);
    rd_chk("remote temp", 8'h04, 32'h10);
    rd_chk("status", 8'h08, 32'h40);
  endtask : t_standby
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_conv();
    t_gap(8'h07, 2500);
    t_gap(8'h06, 5000);
    t_limits();
    t_halt();
    t_addr();
    t_standby();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
